// ==== dtovr_map.svh ====
// Register offsets, field positions, reset values, limits and timing for the overvoltage relay.
`ifndef DTOVR_MAP_SVH
`define DTOVR_MAP_SVH

// Byte addresses of the word registers on the APB slave.
`define DTOVR_OFS_CTRL      8'h00
`define DTOVR_OFS_THRESH    8'h04
`define DTOVR_OFS_HYST      8'h08
`define DTOVR_OFS_DELAY     8'h0C
`define DTOVR_OFS_NOM_PN    8'h10
`define DTOVR_OFS_NOM_PP    8'h14
`define DTOVR_OFS_STATUS    8'h18
`define DTOVR_OFS_IRQ_STAT  8'h1C
`define DTOVR_OFS_IRQ_MASK  8'h20

// Control register fields.
`define DTOVR_CTRL_OPER     0
`define DTOVR_CTRL_STONLY   1
`define DTOVR_CTRL_PP       2

// Reset values of the settings.
`define DTOVR_RST_OPER      1'b0
`define DTOVR_RST_STONLY    1'b0
`define DTOVR_RST_PP        1'b1
`define DTOVR_RST_THRESH    16'd110
`define DTOVR_RST_HYST      16'd5
`define DTOVR_RST_DELAY     16'd100

// Setting ranges; writes outside them are clamped.
`define DTOVR_THRESH_MIN    16'd30
`define DTOVR_THRESH_MAX    16'd130
`define DTOVR_HYST_MIN      16'd1
`define DTOVR_HYST_MAX      16'd10
`define DTOVR_DELAY_MIN     16'd0
`define DTOVR_DELAY_MAX     16'd60000

// Data widths and timing.
`define DTOVR_VOLT_W        16
`define DTOVR_CLK_PERIOD_NS 100
`define DTOVR_MS_IN_NS      1000000
`define DTOVR_CYC_PER_MS    (`DTOVR_MS_IN_NS / `DTOVR_CLK_PERIOD_NS)

`endif

// ==== dtovr_pkg.sv ====
// Types shared by the overvoltage relay modules.
package dtovr_pkg;

   // Per-channel characteristic state.
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_TIMING,
      PH_TRIPPED
   } dtovr_ph_state_t;

   typedef struct packed {
      dtovr_ph_state_t state;
      logic [15:0]     ms_cnt;
      logic            started;
      logic            tripped;
   } dtovr_phase_t;

   // Whole state of the top module.
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        oper_on;
      logic        start_only;
      logic        pp_sel;
      logic [7:0]  thresh;
      logic [3:0]  hyst;
      logic [15:0] delay;
      logic [15:0] nom_pn;
      logic [15:0] nom_pp;
      logic [15:0] presc;
      logic        tick;
      logic [2:0]  start_out;
      logic        gen_start;
      logic        gen_trip;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic        irq;
   } dtovr_top_t;

endpackage

// ==== dtovr_chan_if.sv ====
// Channel bundle between the relay top and one per-channel characteristic.
`timescale 1ns/10ps
`include "dtovr_map.svh"
interface dtovr_chan_if;
   logic                     enable;
   logic [`DTOVR_VOLT_W-1:0] voltage;
   logic [`DTOVR_VOLT_W-1:0] nominal;
   logic [7:0]               thresh;
   logic [3:0]               hyst;
   logic [15:0]              delay;
   logic                     tick;
   logic                     started;
   logic                     tripped;

   modport ctrl (output enable, voltage, nominal, thresh, hyst, delay, tick,
                 input  started, tripped);
   modport chan (input  enable, voltage, nominal, thresh, hyst, delay, tick,
                 output started, tripped);
endinterface

// ==== dtovr_phase.sv ====
// Definite-time characteristic of one measured voltage channel.
`timescale 1ns/10ps
`include "dtovr_map.svh"
module dtovr_phase (
   input  wire logic   clock,
   input  wire logic   rst_b,
   dtovr_chan_if.chan  ch
);

   dtovr_pkg::dtovr_phase_t q;
   dtovr_pkg::dtovr_phase_t d;
   logic                    above;
   logic                    dropped;

   // Product of three factors; 16x8x8 bits always fits in 32.
   function automatic logic [31:0] prod3(input logic [15:0] a, input logic [7:0] b,
                                         input logic [7:0] c);
      prod3 = 32'(a) * 32'(b) * 32'(c);
   endfunction

   // Compare in percent of nominal without a divider; hysteresis is relative to the threshold.
   assign above   = prod3(ch.voltage, 8'h64, 8'h64) > prod3(ch.nominal, ch.thresh, 8'h64);
   assign dropped = prod3(ch.voltage, 8'h64, 8'h64)
                    <= prod3(ch.nominal, ch.thresh, 8'(8'h64 - {4'h0, ch.hyst}));

   // Next state of the channel.
   always_comb begin
      d = q;
      case (q.state)
         dtovr_pkg::PH_IDLE: begin
            d.ms_cnt = 16'h0000;
            if (above) begin
               d.state = dtovr_pkg::PH_TIMING;
            end
         end
         dtovr_pkg::PH_TIMING: begin
            if (dropped) begin
               d.state  = dtovr_pkg::PH_IDLE;
               d.ms_cnt = 16'h0000;
            end else if (q.ms_cnt >= ch.delay) begin
               d.state = dtovr_pkg::PH_TRIPPED;
            end else if (ch.tick && above) begin
               d.ms_cnt = q.ms_cnt + 16'h0001;
            end
         end
         default: begin
            if (dropped) begin
               d.state  = dtovr_pkg::PH_IDLE;
               d.ms_cnt = 16'h0000;
            end
         end
      endcase
      if (!ch.enable) begin
         d.state  = dtovr_pkg::PH_IDLE;
         d.ms_cnt = 16'h0000;
      end
      d.started = d.state != dtovr_pkg::PH_IDLE;
      d.tripped = d.state == dtovr_pkg::PH_TRIPPED;
   end

   // State register.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q <= '{state: dtovr_pkg::PH_IDLE, ms_cnt: 16'h0000, started: 1'b0, tripped: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign ch.started = q.started;
   assign ch.tripped = q.tripped;

endmodule

// ==== dtovr_decide.sv ====
// Decision stage combining the channel statuses into general start and trip.
`timescale 1ns/10ps
module dtovr_decide (
   input  wire logic [2:0] started,
   input  wire logic [2:0] tripped,
   input  wire logic       start_only,
   output logic            gen_start,
   output logic            gen_trip
);

   // Purely combinational; the top registers both results.
   always_comb begin
      gen_start = |started;
      gen_trip  = (|tripped) & ~start_only;
   end

endmodule

// ==== dtovr_top.sv ====
// Definite-time three-channel overvoltage relay with an APB register slave.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "dtovr_map.svh"
module dtovr_top #(
   parameter int unsigned     CYC_PER_MS  = `DTOVR_CYC_PER_MS,
   parameter logic [15:0]     NOMINAL_PN  = 16'h2710,
   parameter logic [15:0]     NOMINAL_PP  = 16'h2710
) (
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   input  wire logic [7:0]               paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [`DTOVR_VOLT_W-1:0] rms_voltage_a,
   input  wire logic [`DTOVR_VOLT_W-1:0] rms_voltage_b,
   input  wire logic [`DTOVR_VOLT_W-1:0] rms_voltage_c,
   input  wire logic                     block_input,
   output logic                          start_phase_a,
   output logic                          start_phase_b,
   output logic                          start_phase_c,
   output logic                          general_start,
   output logic                          general_trip,
   output logic                          irq
);

   // Prescaler terminal count, cut to the prescaler width on purpose.
   localparam logic [15:0] PRESC_LAST = 16'(CYC_PER_MS - 1);

   dtovr_pkg::dtovr_top_t q;
   dtovr_pkg::dtovr_top_t d;

   dtovr_chan_if chan [3] ();

   logic [`DTOVR_VOLT_W-1:0] volt   [3];
   logic [2:0]               started;
   logic [2:0]               tripped;
   logic                     dec_start;
   logic                     dec_trip;
   logic                     enable;
   logic                     acc_phase;
   logic                     done;
   logic                     rd_hit;

   // Clamps a written setting into its legal range.
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      if (v < lo) begin
         clamp = lo;
      end else if (v > hi) begin
         clamp = hi;
      end else begin
         clamp = v;
      end
   endfunction

   // channels are the pairs in phase-to-phase mode
   // The upstream stage forms the pair voltages; only the nominal reference follows the mode.
   assign volt[0] = rms_voltage_a;
   assign volt[1] = rms_voltage_b;
   assign volt[2] = rms_voltage_c;

   assign enable = q.oper_on & ~block_input;

   // Settings fan out to the three channels; each channel keeps its own timer.
   for (genvar i = 0; i < 3; i++) begin : g_chan
      assign chan[i].enable  = enable;
      assign chan[i].voltage = volt[i];
      assign chan[i].nominal = q.pp_sel ? q.nom_pp : q.nom_pn;
      assign chan[i].thresh  = q.thresh;
      assign chan[i].hyst    = q.hyst;
      assign chan[i].delay   = q.delay;
      assign chan[i].tick    = q.tick;
      assign started[i]      = chan[i].started;
      assign tripped[i]      = chan[i].tripped;

      dtovr_phase u_phase (
         .clock (clock),
         .rst_b (rst_b),
         .ch    (chan[i])
      );
   end

   dtovr_decide u_decide (
      .started    (started),
      .tripped    (tripped),
      .start_only (q.start_only),
      .gen_start  (dec_start),
      .gen_trip   (dec_trip)
   );

   // APB phases: one wait state, then the completing edge with pready high.
   assign acc_phase = psel & penable & ~q.pready;
   assign done      = psel & penable & q.pready;

   // Address hit test for the mapped words.
   always_comb begin
      if (paddr == `DTOVR_OFS_CTRL) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_THRESH) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_HYST) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_DELAY) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_NOM_PN) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_NOM_PP) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_STATUS) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_IRQ_STAT) begin
         rd_hit = 1'b1;
      end else if (paddr == `DTOVR_OFS_IRQ_MASK) begin
         rd_hit = 1'b1;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Next state of the whole top.
   always_comb begin
      d         = q;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;

      // Read data is captured one cycle ahead so that prdata leaves a flip-flop.
      if (acc_phase) begin
         d.pready  = 1'b1;
         d.pslverr = ~rd_hit;
         d.prdata  = 32'h0000_0000;
         if (paddr == `DTOVR_OFS_CTRL) begin
            d.prdata[`DTOVR_CTRL_OPER]   = q.oper_on;
            d.prdata[`DTOVR_CTRL_STONLY] = q.start_only;
            d.prdata[`DTOVR_CTRL_PP]     = q.pp_sel;
         end else if (paddr == `DTOVR_OFS_THRESH) begin
            d.prdata[7:0] = q.thresh;
         end else if (paddr == `DTOVR_OFS_HYST) begin
            d.prdata[3:0] = q.hyst;
         end else if (paddr == `DTOVR_OFS_DELAY) begin
            d.prdata[15:0] = q.delay;
         end else if (paddr == `DTOVR_OFS_NOM_PN) begin
            d.prdata[15:0] = q.nom_pn;
         end else if (paddr == `DTOVR_OFS_NOM_PP) begin
            d.prdata[15:0] = q.nom_pp;
         end else if (paddr == `DTOVR_OFS_STATUS) begin
            d.prdata[5:0] = {enable, q.gen_trip, q.gen_start, q.start_out};
         end else if (paddr == `DTOVR_OFS_IRQ_STAT) begin
            d.prdata[3:0] = q.irq_stat;
         end else if (paddr == `DTOVR_OFS_IRQ_MASK) begin
            d.prdata[3:0] = q.irq_mask;
         end
      end

      // Writes land on the completing edge only; unmapped writes are dropped.
      if (done && pwrite) begin
         if (paddr == `DTOVR_OFS_CTRL) begin
            d.oper_on    = pwdata[`DTOVR_CTRL_OPER];
            d.start_only = pwdata[`DTOVR_CTRL_STONLY];
            d.pp_sel     = pwdata[`DTOVR_CTRL_PP];
         end else if (paddr == `DTOVR_OFS_THRESH) begin
            d.thresh = 8'(clamp(pwdata[15:0], `DTOVR_THRESH_MIN, `DTOVR_THRESH_MAX));
         end else if (paddr == `DTOVR_OFS_HYST) begin
            d.hyst = 4'(clamp(pwdata[15:0], `DTOVR_HYST_MIN, `DTOVR_HYST_MAX));
         end else if (paddr == `DTOVR_OFS_DELAY) begin
            d.delay = clamp(pwdata[15:0], `DTOVR_DELAY_MIN, `DTOVR_DELAY_MAX);
         end else if (paddr == `DTOVR_OFS_NOM_PN) begin
            d.nom_pn = pwdata[15:0];
         end else if (paddr == `DTOVR_OFS_NOM_PP) begin
            d.nom_pp = pwdata[15:0];
         end else if (paddr == `DTOVR_OFS_IRQ_MASK) begin
            d.irq_mask = pwdata[3:0];
         end
      end

      // Millisecond tick; it runs free, so a delay may run up to one tick short.
      if (q.presc >= PRESC_LAST) begin
         d.presc = 16'h0000;
         d.tick  = 1'b1;
      end else begin
         d.presc = q.presc + 16'h0001;
         d.tick  = 1'b0;
      end

      // only starts and general flags leave
      // outputs low when off or blocked
      if (enable) begin
         d.start_out = started;
         d.gen_start = dec_start;
         d.gen_trip  = dec_trip;
      end else begin
         d.start_out = 3'b000;
         d.gen_start = 1'b0;
         d.gen_trip  = 1'b0;
      end

      // Read of the interrupt status word clears only the bits it returned; an event that lands
      // after the capture, or in the clearing cycle itself, is kept.
      if (done && !pwrite && paddr == `DTOVR_OFS_IRQ_STAT) begin
         d.irq_stat = q.irq_stat & ~q.prdata[3:0];
      end
      d.irq_stat = d.irq_stat | {d.gen_trip & ~q.gen_trip, d.start_out & ~q.start_out};

      // Level interrupt follows the new status so it lines up with the status register.
      d.irq = |(d.irq_stat & d.irq_mask);
   end

   // The single state register of the top.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q.pready     <= 1'b0;
         q.pslverr    <= 1'b0;
         q.prdata     <= 32'h0000_0000;
         q.oper_on    <= `DTOVR_RST_OPER;
         q.start_only <= `DTOVR_RST_STONLY;
         q.pp_sel     <= `DTOVR_RST_PP;
         q.thresh     <= 8'(`DTOVR_RST_THRESH);
         q.hyst       <= 4'(`DTOVR_RST_HYST);
         q.delay      <= `DTOVR_RST_DELAY;
         q.nom_pn     <= NOMINAL_PN;
         q.nom_pp     <= NOMINAL_PP;
         q.presc      <= 16'h0000;
         q.tick       <= 1'b0;
         q.start_out  <= 3'b000;
         q.gen_start  <= 1'b0;
         q.gen_trip   <= 1'b0;
         q.irq_stat   <= 4'h0;
         q.irq_mask   <= 4'h0;
         q.irq        <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Every output is taken straight from the state register.
   assign prdata        = q.prdata;
   assign pready        = q.pready;
   assign pslverr       = q.pslverr;
   assign start_phase_a = q.start_out[0];
   assign start_phase_b = q.start_out[1];
   assign start_phase_c = q.start_out[2];
   assign general_start = q.gen_start;
   assign general_trip  = q.gen_trip;
   assign irq           = q.irq;

endmodule

// ==== dtovr_props.sv ====
// Port checker for the overvoltage relay top.
`timescale 1ns/10ps
`include "dtovr_map.svh"
module dtovr_props #(
   parameter int unsigned CYC_PER_MS = 10
) (
   input wire logic                     clock,
   input wire logic                     rst_b,
   input wire logic [7:0]               paddr,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic [`DTOVR_VOLT_W-1:0] rms_voltage_a,
   input wire logic [`DTOVR_VOLT_W-1:0] rms_voltage_b,
   input wire logic [`DTOVR_VOLT_W-1:0] rms_voltage_c,
   input wire logic                     block_input,
   input wire logic                     start_phase_a,
   input wire logic                     start_phase_b,
   input wire logic                     start_phase_c,
   input wire logic                     general_start,
   input wire logic                     general_trip,
   input wire logic                     irq
);
   // All checks share the relay clock and its reset.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // Steps that lead to a forced dropoff.
   sequence volts_zero;
      (rms_voltage_a == 16'h0000) && (rms_voltage_b == 16'h0000) && (rms_voltage_c == 16'h0000);
   endsequence
   sequence blocked_long;
      block_input [*3];
   endsequence

   gen_start_or_a: assert property (
      general_start == (start_phase_a | start_phase_b | start_phase_c))
      else $error("general start differs from phase starts");
   trip_has_start_a: assert property (
      general_trip |-> (start_phase_a | start_phase_b | start_phase_c))
      else $error("trip without any phase start");
   trip_after_start_a: assert property (
      $rose(general_trip) |-> $past(general_start))
      else $error("trip rose without earlier start");
   start_cause_a: assert property (
      $rose(start_phase_a) |-> $past(rms_voltage_a, 2) != 16'h0000)
      else $error("phase a start with no voltage");
   zero_drop_a: assert property (
      volts_zero ##1 volts_zero |=> !general_start && !general_trip)
      else $error("start held with zero voltage");
   block_clear_a: assert property (
      blocked_long |=> !general_start && !general_trip)
      else $error("outputs active while blocked");
   start_unblocked_a: assert property (
      $rose(general_start) |-> !$past(block_input))
      else $error("start rose while blocked");
   reset_quiet_a: assert property (
      $rose(rst_b) |-> (!general_start && !general_trip && !irq) [*4])
      else $error("outputs active right after reset");
endmodule

bind dtovr_top dtovr_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
   .clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rms_voltage_a(rms_voltage_a), .rms_voltage_b(rms_voltage_b),
   .rms_voltage_c(rms_voltage_c), .block_input(block_input),
   .start_phase_a(start_phase_a), .start_phase_b(start_phase_b),
   .start_phase_c(start_phase_c), .general_start(general_start),
   .general_trip(general_trip), .irq(irq));

// ==== dtovr_rms_src.sv ====
// Model of the upstream RMS measurement stage.
`timescale 1ns/10ps
module dtovr_rms_src (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic [15:0] level_a,
   input wire logic [15:0] level_b,
   input wire logic [15:0] level_c,
   output logic     [15:0] rms_a,
   output logic     [15:0] rms_b,
   output logic     [15:0] rms_c
);
   // fundamental RMS values
   // Each result lands one cycle after its level, as a real calculation would lag.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         {rms_a, rms_b, rms_c} <= 48'h0;
      end else begin
         {rms_a, rms_b, rms_c} <= {level_a, level_b, level_c};
      end
   end
endmodule

// ==== definite_time_overvoltage_relay_tb.sv ====
// Self-checking bench of the overvoltage relay.
`timescale 1ns/10ps
`include "dtovr_map.svh"
module definite_time_overvoltage_relay_tb;
   logic        clock, rst_b, psel, penable, pwrite, block_input, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] lv_a, lv_b, lv_c, va, vb, vc;
   logic        st_a, st_b, st_c, gen_st, gen_tr, err, hit;
   int          n_errors, num_checks, n;

   dtovr_rms_src src (.clock(clock), .rst_b(rst_b), .level_a(lv_a), .level_b(lv_b),
      .level_c(lv_c), .rms_a(va), .rms_b(vb), .rms_c(vc));
   dtovr_top #(.CYC_PER_MS(10)) dut (.clock(clock), .rst_b(rst_b), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rms_voltage_a(va), .rms_voltage_b(vb),
      .rms_voltage_c(vc), .block_input(block_input), .start_phase_a(st_a),
      .start_phase_b(st_b), .start_phase_c(st_c), .general_start(gen_st),
      .general_trip(gen_tr), .irq(irq));

   // Free-running 10 MHz clock.
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // One APB transfer; a slave that never answers ends the run.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         finish_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] e, input string name);
      apb(1'b0, a, 32'h0);
      check(name, rd, e);
   endtask

   // Sampling is done at the falling edge, where outputs have settled.
   task cyc_look(input int c);
      repeat (c) @(posedge clock);
      @(negedge clock);
   endtask

   task wtrip;
      n = 0;
      while (gen_tr !== 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 2000) begin
         n_errors++;
         finish_test;
      end
   endtask

   task t_defaults;
      @(posedge clock) lv_a <= 16'h2EE0;
      cyc_look(5);
      check("start while off", {gen_st, st_a}, 32'h0);
      rchk(`DTOVR_OFS_CTRL, 32'h4, "ctrl");
      rchk(`DTOVR_OFS_THRESH, 32'h6E, "thresh");
      rchk(`DTOVR_OFS_HYST, 32'h5, "hyst");
      rchk(`DTOVR_OFS_DELAY, 32'h64, "delay");
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      @(posedge clock) lv_a <= 16'h0;
   endtask

   task t_limits;
      apb(1'b1, `DTOVR_OFS_THRESH, 32'h14);
      rchk(`DTOVR_OFS_THRESH, 32'h1E, "thresh low");
      apb(1'b1, `DTOVR_OFS_THRESH, 32'hC8);
      rchk(`DTOVR_OFS_THRESH, 32'h82, "thresh high");
      apb(1'b1, `DTOVR_OFS_HYST, 32'h0);
      rchk(`DTOVR_OFS_HYST, 32'h1, "hyst low");
      apb(1'b1, `DTOVR_OFS_HYST, 32'hF);
      rchk(`DTOVR_OFS_HYST, 32'hA, "hyst high");
      apb(1'b1, `DTOVR_OFS_DELAY, 32'hFFFF);
      rchk(`DTOVR_OFS_DELAY, 32'hEA60, "delay high");
      apb(1'b1, `DTOVR_OFS_THRESH, 32'h6E);
      apb(1'b1, `DTOVR_OFS_HYST, 32'h5);
   endtask

   task t_start;
      apb(1'b1, `DTOVR_OFS_DELAY, 32'h2);
      apb(1'b1, `DTOVR_OFS_IRQ_MASK, 32'hF);
      apb(1'b1, `DTOVR_OFS_CTRL, 32'h5);
      @(posedge clock) lv_a <= 16'h2AF9;
      cyc_look(3);
      check("start a", {st_c, st_b, st_a, gen_st, gen_tr}, 32'h6);
      wtrip;
      check("trip time", (n + 3 >= 10 && n + 3 <= 28), 32'h1);
      check("irq raised", irq, 32'h1);
      rchk(`DTOVR_OFS_IRQ_STAT, 32'h9, "irq stat");
      cyc_look(1);
      check("irq cleared", irq, 32'h0);
      @(posedge clock) lv_a <= 16'h2904;
      cyc_look(6);
      check("in band held", {st_a, gen_tr}, 32'h3);
      @(posedge clock) lv_a <= 16'h28D2;
      cyc_look(3);
      check("dropoff", {st_a, gen_st, gen_tr}, 32'h0);
      apb(1'b1, `DTOVR_OFS_IRQ_MASK, 32'h0);
      @(posedge clock) lv_b <= 16'h2EE0;
      cyc_look(3);
      check("masked irq", {st_b, irq}, 32'h2);
      rchk(`DTOVR_OFS_IRQ_STAT, 32'h2, "masked stat");
      @(posedge clock) lv_b <= 16'h0;
   endtask

   task t_restart;
      apb(1'b1, `DTOVR_OFS_DELAY, 32'h3);
      @(posedge clock) lv_b <= 16'h2EE0;
      repeat (20) @(posedge clock);
      lv_b <= 16'h0;
      repeat (4) @(posedge clock);
      lv_b <= 16'h2EE0;
      hit = 1'b0;
      repeat (20) begin
         @(posedge clock);
         hit |= gen_tr;
      end
      check("no early trip", hit, 32'h0);
      wtrip;
      check("trip after restart", st_b, 32'h1);
      @(posedge clock) lv_b <= 16'h0;
   endtask

   task t_stonly;
      apb(1'b1, `DTOVR_OFS_DELAY, 32'h0);
      apb(1'b1, `DTOVR_OFS_CTRL, 32'h7);
      @(posedge clock) lv_c <= 16'h2EE0;
      cyc_look(30);
      check("start only", {st_c, gen_tr}, 32'h2);
      rchk(`DTOVR_OFS_STATUS, 32'h2C, "status word");
      @(posedge clock) block_input <= 1'b1;
      cyc_look(3);
      check("blocked", {st_c, gen_st}, 32'h0);
      @(posedge clock) block_input <= 1'b0;
      apb(1'b1, `DTOVR_OFS_CTRL, 32'h5);
      wtrip;
      check("zero delay", {st_c, gen_tr}, 32'h3);
      apb(1'b1, `DTOVR_OFS_CTRL, 32'h4);
      cyc_look(2);
      check("oper off", {st_c, gen_st, gen_tr}, 32'h0);
      @(posedge clock) lv_c <= 16'h0;
   endtask

   task t_pp;
      apb(1'b1, `DTOVR_OFS_NOM_PP, 32'h1388);
      apb(1'b1, `DTOVR_OFS_CTRL, 32'h5);
      @(posedge clock) lv_a <= 16'h15E0;
      cyc_look(3);
      check("pair start", st_a, 32'h1);
      apb(1'b1, `DTOVR_OFS_CTRL, 32'h1);
      cyc_look(3);
      check("phase mode", st_a, 32'h0);
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      n_errors = 0;
      num_checks = 0;
      rst_b = 1'b0;
      {psel, penable, pwrite, block_input} = 4'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {lv_a, lv_b, lv_c} = 48'h0;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      t_defaults;
      t_limits;
      t_start;
      t_restart;
      t_stonly;
      t_pp;
      finish_test;
   end
endmodule
